/* src/odt_pkg.sv */
package odt_pkg;
  // Mode register bit positions
  localparam int MR1_RTT_A2 = 2;
  localparam int MR1_RTT_A6 = 6;
  localparam int MR1_RTT_A9 = 9;
  localparam int MR1_TDQS_A11 = 11;
  localparam int MR1_AL_LO = 3;
  localparam int MR2_CWL_LO = 3;
  localparam int MR2_RTTWR_A9 = 9;
  localparam int MR2_RTTWR_A10 = 10;
  localparam int MR0_PPD_A12 = 12;
  localparam int MR1_DLL_A0 = 0;
  // Timing in clock cycles
  localparam logic [3:0] TERM_MIN_HIGH_SHORT = 4'h4;
  localparam logic [3:0] TERM_MIN_HIGH_LONG = 4'h6;
  localparam logic [4:0] TERM_LAT_OFFSET = 5'h02;
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam int DLY_DEPTH = 32;
  // Controller register offsets (APB)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MR0 = 8'h04;
  localparam logic [7:0] REG_MR1 = 8'h08;
  localparam logic [7:0] REG_MR2 = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  // CTRL fields
  localparam int CTRL_ODT_REQ = 0;
  localparam int CTRL_DLL_OFF = 1;
  localparam int CTRL_BL8 = 2;
  // CMD fields: bit0 write, bit1 read, bit2 mrs
  localparam int CMD_WR = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_MRS = 2;
  localparam logic [15:0] MR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ODT_IDLE = 2'b00,
    ODT_HIGH = 2'b01,
    ODT_HOLD = 2'b10
  } odt_state_e;

  function automatic logic [4:0] term_latency(input logic [15:0] mr1, input logic [15:0] mr2);
    logic [4:0] al;
    logic [4:0] cas_write_latency;
    al = 5'h00;
    cas_write_latency = CWL_BASE + {2'b00, mr2[MR2_CWL_LO +: 3]};
    unique case (mr1[MR1_AL_LO +: 2])
      2'b01: al = cas_write_latency - 5'h01;
      2'b10: al = cas_write_latency - 5'h02;
      default: al = 5'h00;
    endcase
    term_latency = cas_write_latency + al - TERM_LAT_OFFSET;
  endfunction

  function automatic logic term_enabled(input logic [15:0] mr1, input logic [15:0] mr2);
    term_enabled = mr1[MR1_RTT_A9] | mr1[MR1_RTT_A6] | mr1[MR1_RTT_A2] | mr2[MR2_RTTWR_A10] | mr2[MR2_RTTWR_A9];
  endfunction
endpackage

/* src/odt_if.sv */
`timescale 1ns/1ns
interface odt_if;
  logic odt;
  logic wr_cmd;
  logic rd_cmd;
  logic mrs_cmd;
  logic [1:0] mrs_sel;
  logic [15:0] mrs_data;
  logic self_refresh;
  logic cke;
  modport device (input odt, wr_cmd, rd_cmd, mrs_cmd, mrs_sel, mrs_data, self_refresh, cke);
  modport ctrl (output odt, wr_cmd, rd_cmd, mrs_cmd, mrs_sel, mrs_data, self_refresh, cke);
endinterface

/* src/odt_delay.sv */
`timescale 1ns/1ns
module odt_delay (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Data
  input wire logic din,
  input wire logic [4:0] lat,
  output logic dout
);
  typedef struct packed {
    logic [odt_pkg::DLY_DEPTH-1:0] sr;
  } odt_dly_s;
  odt_dly_s st, next_st;

  always_comb begin
    next_st = st;
    next_st.sr = {st.sr[odt_pkg::DLY_DEPTH-2:0], din};
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // Tap is unregistered: the user's output flop completes the latency
  assign dout = (lat == 5'h00) ? din : st.sr[lat - 5'h01];
endmodule // odt_delay

/* src/odt_dram_end.sv */
`timescale 1ns/1ns
module odt_dram_end (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Link
  odt_if.device link,
  // Termination outputs
  output logic TERM_DATA_ON,
  output logic TERM_TDQS_ON,
  output logic [2:0] RTT_NOM_SEL,
  output logic [1:0] RTT_WR_SEL,
  output logic SYNC_MODE
);
  typedef struct packed {
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic data_on;
    logic tdqs_on;
    logic [2:0] nom;
    logic [1:0] wr;
    logic sync;
  } odt_dev_s;
  odt_dev_s st, next_st;
  logic gated_pin;
  logic delayed_pin;
  logic [4:0] lat;

  always_comb begin
    lat = odt_pkg::term_latency(st.mr1, st.mr2);
    // Pin ignored when disabled or in self-refresh
    gated_pin = link.odt & odt_pkg::term_enabled(st.mr1, st.mr2) & ~link.self_refresh;
  end

  odt_delay u_delay (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .din(gated_pin),
    .lat(lat),
    .dout(delayed_pin)
  );

  always_comb begin
    next_st = st;
    if (link.mrs_cmd) begin
      unique case (link.mrs_sel)
        2'b00: next_st.mr0 = link.mrs_data;
        2'b01: next_st.mr1 = link.mrs_data;
        2'b10: next_st.mr2 = link.mrs_data;
        default: next_st.mr0 = st.mr0;
      endcase
    end
    // DLL on: MR1 A0 clear; precharge power-down needs MR0 A12
    next_st.sync = ~st.mr1[odt_pkg::MR1_DLL_A0] & ~link.self_refresh & (link.cke | st.mr0[odt_pkg::MR0_PPD_A12]);
    next_st.data_on = delayed_pin & ~link.self_refresh;
    next_st.tdqs_on = delayed_pin & ~link.self_refresh & st.mr1[odt_pkg::MR1_TDQS_A11];
    next_st.nom = {st.mr1[odt_pkg::MR1_RTT_A9], st.mr1[odt_pkg::MR1_RTT_A6], st.mr1[odt_pkg::MR1_RTT_A2]};
    next_st.wr = {st.mr2[odt_pkg::MR2_RTTWR_A10], st.mr2[odt_pkg::MR2_RTTWR_A9]};
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign TERM_DATA_ON = st.data_on;
  assign TERM_TDQS_ON = st.tdqs_on;
  assign RTT_NOM_SEL = st.nom;
  assign RTT_WR_SEL = st.wr;
  assign SYNC_MODE = st.sync;
endmodule // odt_dram_end

/* src/odt_ctrl_end.sv */
`timescale 1ns/1ns
module odt_ctrl_end (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Link
  odt_if.ctrl link
);
  typedef struct packed {
    logic [2:0] ctrl;
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    odt_pkg::odt_state_e state;
    logic [3:0] hold;
    logic odt;
    logic wr;
    logic rd;
    logic mrs;
    logic [1:0] sel;
    logic [15:0] data;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } odt_ctl_s;
  odt_ctl_s st, next_st;
  logic access;
  logic want_high;

  always_comb begin
    next_st = st;
    access = PSEL & PENABLE & ~st.pready;
    next_st.pready = access;
    next_st.pslverr = 1'b0;
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    next_st.mrs = 1'b0;
    // DLL-off masks the request; a pin already high stays up until its hold ends
    want_high = st.ctrl[odt_pkg::CTRL_ODT_REQ] & ~st.ctrl[odt_pkg::CTRL_DLL_OFF];
    if (access) begin
      next_st.prdata = 32'h0000_0000;
      unique case (PADDR)
        odt_pkg::REG_CTRL: begin
          if (PWRITE) next_st.ctrl = PWDATA[2:0];
          next_st.prdata = {29'h0000_0000, st.ctrl};
        end
        odt_pkg::REG_MR0: begin
          if (PWRITE) next_st.mr0 = PWDATA[15:0];
          next_st.prdata = {16'h0000, st.mr0};
        end
        odt_pkg::REG_MR1: begin
          if (PWRITE) next_st.mr1 = PWDATA[15:0];
          next_st.prdata = {16'h0000, st.mr1};
        end
        odt_pkg::REG_MR2: begin
          if (PWRITE) next_st.mr2 = PWDATA[15:0];
          next_st.prdata = {16'h0000, st.mr2};
        end
        odt_pkg::REG_CMD: begin
          if (PWRITE) begin
            next_st.wr = PWDATA[odt_pkg::CMD_WR];
            next_st.rd = PWDATA[odt_pkg::CMD_RD];
            next_st.mrs = PWDATA[odt_pkg::CMD_MRS];
            next_st.sel = PWDATA[5:4];
            next_st.data = (PWDATA[5:4] == 2'b00) ? st.mr0 : (PWDATA[5:4] == 2'b01) ? st.mr1 : st.mr2;
          end
        end
        odt_pkg::REG_STATUS: next_st.prdata = {26'h0000000, st.hold, st.state};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    unique case (st.state)
      odt_pkg::ODT_IDLE: begin
        if (want_high) begin
          next_st.odt = 1'b1;
          next_st.state = odt_pkg::ODT_HIGH;
          next_st.hold = odt_pkg::TERM_MIN_HIGH_SHORT - 4'h1;
        end
      end
      odt_pkg::ODT_HIGH: begin
        if (st.hold != 4'h0) next_st.hold = st.hold - 4'h1;
        // Write with pin high extends the hold to at least the minimum for the burst: TERM_MIN_HIGH_LONG with CTRL_BL8, else TERM_MIN_HIGH_SHORT
        if (st.wr) begin
          // Remaining count already saturated; keep the later deadline
          if (st.ctrl[odt_pkg::CTRL_BL8]) begin
            if (next_st.hold < odt_pkg::TERM_MIN_HIGH_LONG - 4'h1) begin
              next_st.hold = odt_pkg::TERM_MIN_HIGH_LONG - 4'h1;
            end
          end else begin
            if (next_st.hold < odt_pkg::TERM_MIN_HIGH_SHORT - 4'h1) begin
              next_st.hold = odt_pkg::TERM_MIN_HIGH_SHORT - 4'h1;
            end
          end
        end else if (st.hold == 4'h0 && !want_high) begin
          next_st.odt = 1'b0;
          next_st.state = odt_pkg::ODT_HOLD;
        end
      end
      odt_pkg::ODT_HOLD: next_st.state = odt_pkg::ODT_IDLE;
      default: next_st.state = odt_pkg::ODT_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign link.odt = st.odt;
  assign link.wr_cmd = st.wr;
  assign link.rd_cmd = st.rd;
  assign link.mrs_cmd = st.mrs;
  assign link.mrs_sel = st.sel;
  assign link.mrs_data = st.data;
  assign link.self_refresh = 1'b0;
  assign link.cke = 1'b1;
endmodule // odt_ctrl_end

/* tb/odt_properties.sv */
`timescale 1ns/1ns
module odt_properties (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Link
  input wire logic odt,
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  // Device outputs
  input wire logic TERM_DATA_ON,
  input wire logic TERM_TDQS_ON,
  input wire logic [2:0] RTT_NOM_SEL,
  input wire logic [1:0] RTT_WR_SEL
);
  logic [4:0] low_run;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Cycles the pin has been registered low, saturating
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      low_run <= 5'h00;
    end else if (odt) begin
      low_run <= 5'h00;
    end else if (low_run != 5'h1F) begin
      low_run <= low_run + 5'h01;
    end
  end
  a_odt_min_high: assert property ($rose(odt) |-> odt [*4]) else $error("odt high too short");
  a_wr_hold: assert property (wr_cmd && odt |-> odt [*4]) else $error("odt low after write");
  a_tdqs_gated: assert property (TERM_TDQS_ON |-> TERM_DATA_ON) else $error("tdqs without data");
  a_rtt_off: assert property (RTT_NOM_SEL == 3'h0 && RTT_WR_SEL == 2'h0 |-> !TERM_DATA_ON)
    else $error("term on while disabled");
  a_low_off: assert property (low_run >= 5'h17 |-> !TERM_DATA_ON) else $error("term stays on");
  a_rd_odt_low: assert property (rd_cmd |-> !odt) else $error("read with odt high");
  a_wr_pulse: assert property (wr_cmd |=> !wr_cmd) else $error("write pulse too long");
  a_odt_gap: assert property ($fell(odt) |=> !odt) else $error("odt reasserted at once");
endmodule // odt_properties

/* tb/tb_ddr_on_die_termination_ctrl.sv */
`timescale 1ns/1ns
module tb_ddr_on_die_termination_ctrl;
  logic CLK_SYS, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, serr;
  logic TERM_DATA_ON, TERM_TDQS_ON, SYNC_MODE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic [2:0] RTT_NOM_SEL;
  logic [1:0] RTT_WR_SEL;
  logic [15:0] m1 [2] = '{16'h0004, 16'h0A08};
  logic [15:0] m2 [2] = '{16'h0000, 16'h0200};
  int lt [2] = '{3, 7};
  int errors, check_count, n;
  odt_if odt_if_i ();
  odt_ctrl_end odt_ctrl_end_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .link(odt_if_i.ctrl));
  odt_dram_end odt_dram_end_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .link(odt_if_i.device),
    .TERM_DATA_ON(TERM_DATA_ON), .TERM_TDQS_ON(TERM_TDQS_ON), .RTT_NOM_SEL(RTT_NOM_SEL),
    .RTT_WR_SEL(RTT_WR_SEL), .SYNC_MODE(SYNC_MODE));
  odt_properties odt_properties_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .odt(odt_if_i.odt),
    .wr_cmd(odt_if_i.wr_cmd), .rd_cmd(odt_if_i.rd_cmd), .TERM_DATA_ON(TERM_DATA_ON),
    .TERM_TDQS_ON(TERM_TDQS_ON), .RTT_NOM_SEL(RTT_NOM_SEL), .RTT_WR_SEL(RTT_WR_SEL));
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  task automatic give_verdict;
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 40) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      k++;
    end while (PREADY !== 1'b1 && k < 40);
    bound(k);
    rdata = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Edges from odt registered at v until termination shows v
  task automatic lat_of(input logic v, output int k);
    k = 0;
    while (odt_if_i.odt !== v && k < 40) begin
      @(negedge CLK_SYS);
      k++;
    end
    bound(k);
    k = 0;
    while (TERM_DATA_ON !== v && k < 40) begin
      @(negedge CLK_SYS);
      k++;
    end
    bound(k);
  endtask
  // Edges with odt registered high from the write on
  task automatic hold_of(output int k);
    k = 0;
    while (odt_if_i.wr_cmd !== 1'b1 && k < 40) begin
      @(negedge CLK_SYS);
      k++;
    end
    bound(k);
    k = 0;
    while (odt_if_i.odt === 1'b1 && k < 40) begin
      @(negedge CLK_SYS);
      k++;
    end
    bound(k);
  endtask
  initial begin
    errors = 0;
    check_count = 0;
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    repeat (10) @(posedge CLK_SYS);
    RESET <= 1'b0;
    apb(1'b0, odt_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, rdata);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, 32'(serr));
    // Mode registers still zero
    apb(1'b1, odt_pkg::REG_CTRL, 32'h1);
    repeat (12) @(posedge CLK_SYS);
    chk("term_dis", 32'h0, 32'(TERM_DATA_ON));
    apb(1'b1, odt_pkg::REG_CTRL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, odt_pkg::REG_MR1, 32'(m1[i]));
      apb(1'b1, odt_pkg::REG_CMD, 32'h14);
      apb(1'b1, odt_pkg::REG_MR2, 32'(m2[i]));
      apb(1'b1, odt_pkg::REG_CMD, 32'h24);
      apb(1'b1, odt_pkg::REG_CTRL, 32'h1);
      lat_of(1'b1, n);
      chk("on_lat", 32'(lt[i] + 1), 32'(n));
      chk("tdqs", 32'(m1[i][11]), 32'(TERM_TDQS_ON));
      chk("rtt_nom", 32'({m1[i][9], m1[i][6], m1[i][2]}), 32'(RTT_NOM_SEL));
      chk("rtt_wr", 32'({m2[i][10], m2[i][9]}), 32'(RTT_WR_SEL));
      chk("sync", 32'h1, 32'(SYNC_MODE));
      apb(1'b1, odt_pkg::REG_CTRL, 32'h0);
      lat_of(1'b0, n);
      chk("off_lat", 32'(lt[i] + 1), 32'(n));
    end
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, odt_pkg::REG_CTRL, 32'(b * 4 + 1));
      fork
        begin
          apb(1'b1, odt_pkg::REG_CMD, 32'h1);
          apb(1'b1, odt_pkg::REG_CTRL, 32'(b * 4));
        end
        hold_of(n);
      join
      chk("wr_hold", 32'h1, 32'(n >= (b ? 6 : 4)));
      lat_of(1'b0, n);
    end
    apb(1'b1, odt_pkg::REG_CMD, 32'h2);
    chk("rd_term", 32'h0, 32'(TERM_DATA_ON));
    apb(1'b1, odt_pkg::REG_CTRL, 32'h3);
    repeat (4) @(posedge CLK_SYS);
    chk("dll_off", 32'h0, 32'(odt_if_i.odt));
    // DLL disabled through the mode register leaves synchronous mode
    apb(1'b1, odt_pkg::REG_MR1, 32'h1);
    apb(1'b1, odt_pkg::REG_CMD, 32'h14);
    repeat (4) @(posedge CLK_SYS);
    chk("sync_off", 32'h0, 32'(SYNC_MODE));
    give_verdict();
  end
endmodule // tb_ddr_on_die_termination_ctrl
